// File: rtl/memory_decode_remap_regs.svh
/*
 * Address map, boot and timing constants of the memory decode and remap block.
 * Assumes a 32-bit little-endian internal address bus from the core.
 */
// Overview of operation
// (R01) Low 4 MB internal memory, top 4 MB peripherals, rest external bus.
// (R02) All spaces are little-endian only.
// (R03) Internal memories are 32-bit and answer any access in one cycle.
// (R04) Primary SRAM at 0x300000 before remap, at zero after remap.
// (R05) Secondary 128 KB bank decoded at 0x100000 when present.
// (R06) Secondary SRAM write-protected after reset; writing 0x1 to mode register unprotects.
// (R07) Boot choice sampled from boot select pin in last 10 cycles of reset.
// (R08) Pin low: 16-bit external boot; high: 8-bit external or internal bank.
// (R09) Boot select pad becomes I/O line 24 after reset.
// (R10) Exception vectors 0x0 to 0x20 come from memory decoded at zero.
// (R11) Writing one to the remap bit swaps zero to primary SRAM.
// (R12) Software remaps before using chip selects 1 to 7.
// (R13) Remap sticks until internal or external reset.
// (R14) Abort on undefined address in external bus space.
// (R15) Write to protected memory aborts but still proceeds.
// (R16) No abort for internal memory reads or any peripheral access.
// (R17) 0x400000 up to 0xffc00000 routes to the external bus unit.
// (R18) Peripheral access is word-only; low address bits are cleared.
// (R19) Each peripheral gets a 16 KB slot, interrupt controller only 4 KB.
// (R20) External system boots first, loads SRAM, flips boot pin, resets again.
// (R21) Watchdog reset keeps boot mode and does not resample pins.
// (R22) Before remap the lowest megabyte decodes to the boot memory.
`ifndef MEMORY_DECODE_REMAP_REGS_SVH
`define MEMORY_DECODE_REMAP_REGS_SVH
`define MDR_MB_LSB 20
`define MDR_INT_TOP 12'h003
`define MDR_PER_TOP 10'h3ff
`define MDR_MB_ZERO 12'h000
`define MDR_MB_SEC 12'h001
`define MDR_MB_PRI 12'h003
`define MDR_MODE_UNPROT 32'h0000_0001
`define MDR_BOOT_CYCLES 4'ha
`define MDR_SLOT_LSB 14
`define MDR_AIC_SLOT 8'hff
`define MDR_AIC_LSB 12
`define MDR_VEC_TOP 32'h0000_0020
`endif

// File: rtl/memory_decode_remap_pkg.sv
/*
 * Types of the memory decode and remap block.
 * Assumes the constants header is compiled alongside.
 */
package memory_decode_remap_pkg;
    typedef enum logic [1:0] {
        SPACE_INT = 2'b00,
        SPACE_EXT = 2'b01,
        SPACE_PER = 2'b11
    } space_e;
    typedef enum logic [2:0] {
        TGT_NONE = 3'h0,
        TGT_PRI = 3'h1,
        TGT_SEC = 3'h2,
        TGT_EXT = 3'h3,
        TGT_PER = 3'h4
    } target_e;
    typedef enum logic [1:0] {
        BOOT_EXT16 = 2'b00,
        BOOT_EXT8 = 2'b01,
        BOOT_INT = 2'b11
    } boot_e;
endpackage

// File: rtl/memory_decode_remap.sv
/*
 * Memory controller address decoder: space split, boot select, remap,
 * secondary bank write protect, abort and peripheral slot decode.
 * Assumes the core drives a request with address, size and write one cycle
 * at a time; the external bus unit reports which external addresses exist.
 */
`timescale 1ns/1ps
`include "memory_decode_remap_regs.svh"
module memory_decode_remap #(
    parameter bit HAS_SEC = 1'b1,
    parameter bit SEC_IS_ROM = 1'b0
) (
    // Clock and resets
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    input wire logic wd_reset_i,
    // Boot strap pad
    input wire logic boot_select_pin_i,
    // Core request
    input wire logic req_i,
    input wire logic req_write_i,
    input wire logic [1:0] req_size_i,
    input wire logic [31:0] req_addr_i,
    // Control writes and external address valid
    input wire logic remap_wr_i,
    input wire logic [31:0] remap_wdata_i,
    input wire logic mode_wr_i,
    input wire logic [31:0] mode_wdata_i,
    input wire logic ext_addr_valid_i,
    // Decode results
    output memory_decode_remap_pkg::space_e space_o,
    output memory_decode_remap_pkg::target_e target_o,
    output logic [31:0] mem_addr_o,
    output logic chip_select_zero_o,
    output logic [7:0] per_slot_o,
    output logic aic_sel_o,
    output logic abort_o,
    output logic access_ok_o,
    // Status
    output logic remap_bit_o,
    output logic sec_protect_o,
    output memory_decode_remap_pkg::boot_e boot_mode_o,
    output logic io_line_24_en_o,
    output logic in_reset_o
);
    import memory_decode_remap_pkg::*;

    logic bsel_meta_q, bsel_sync_q;
    logic rst_meta_q, rst_sync_q;
    logic [3:0] low_cnt_q, high_cnt_q;
    boot_e boot_q;
    logic remap_q, prot_q, rst_seen_q;
    logic [11:0] mb;
    logic per_hit, int_hit;

    // Pad and reset level synchronisers, free of reset so the pad is seen during reset
    always_ff @(posedge mclk_i)
    begin
        bsel_meta_q <= boot_select_pin_i;
        bsel_sync_q <= bsel_meta_q;
        rst_meta_q <= sys_rst_i;
        rst_sync_q <= rst_meta_q;
    end

    // Reset release tracking, pad handover to I/O line 24
    always_ff @(posedge mclk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            rst_seen_q <= 1'b0;
        else
            rst_seen_q <= 1'b1;
    end
    assign in_reset_o = !rst_seen_q;
    assign io_line_24_en_o = rst_seen_q; // R09

    // Count steady level of the pad while reset is held, saturating
    always_ff @(posedge mclk_i)
    begin
        if (rst_sync_q)
        begin
            if (bsel_sync_q)
            begin
                low_cnt_q <= 4'h0;
                if (high_cnt_q != `MDR_BOOT_CYCLES)
                    high_cnt_q <= high_cnt_q + 4'h1; // R07
            end
            else
            begin
                high_cnt_q <= 4'h0;
                if (low_cnt_q != `MDR_BOOT_CYCLES)
                    low_cnt_q <= low_cnt_q + 4'h1; // R07
            end
        end
        else
        begin
            low_cnt_q <= 4'h0;
            high_cnt_q <= 4'h0;
        end
    end

    // Boot mode caught at the first edge after release, watchdog keeps it
    always_ff @(posedge mclk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            boot_q <= BOOT_EXT16;
        else if (!rst_seen_q)
        begin
            if (high_cnt_q != `MDR_BOOT_CYCLES) // R07
                boot_q <= BOOT_EXT16; // R08
            else if (HAS_SEC)
                boot_q <= BOOT_INT; // R08
            else
                boot_q <= BOOT_EXT8; // R08
        end
    end
    assign boot_mode_o = boot_q; // R21

    // Remap is set only; both resets clear it
    always_ff @(posedge mclk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            remap_q <= 1'b0;
        else if (wd_reset_i)
            remap_q <= 1'b0; // R13
        else if (remap_wr_i && remap_wdata_i[0])
            remap_q <= 1'b1; // R11
    end
    assign remap_bit_o = remap_q;

    // Secondary bank protection
    always_ff @(posedge mclk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            prot_q <= 1'b1;
        else if (wd_reset_i)
            prot_q <= 1'b1; // R06
        else if (mode_wr_i)
            prot_q <= (mode_wdata_i != `MDR_MODE_UNPROT); // R06
    end
    assign sec_protect_o = prot_q || SEC_IS_ROM;

    // Address decode
    assign mb = req_addr_i[31:`MDR_MB_LSB];
    assign int_hit = (mb <= `MDR_INT_TOP); // R01
    assign per_hit = (req_addr_i[31:22] == `MDR_PER_TOP); // R01 R17

    always_comb
    begin
        space_o = SPACE_EXT; // R17
        target_o = TGT_EXT;
        chip_select_zero_o = 1'b0;
        mem_addr_o = req_addr_i; // R02
        if (per_hit)
        begin
            space_o = SPACE_PER;
            target_o = TGT_PER;
            mem_addr_o = {req_addr_i[31:2], 2'b00}; // R18
        end
        else if (int_hit)
        begin
            space_o = SPACE_INT;
            target_o = TGT_NONE;
            if (mb == `MDR_MB_ZERO)
            begin
                // Vectors at zero come from whatever is decoded here
                if (remap_q)
                    target_o = TGT_PRI; // R04 R10
                else if (boot_q == BOOT_INT)
                    target_o = TGT_SEC; // R22
                else
                begin
                    target_o = TGT_EXT; // R22
                    chip_select_zero_o = 1'b1; // R08
                end
            end
            else if (mb == `MDR_MB_SEC && HAS_SEC)
                target_o = TGT_SEC; // R05
            else if (mb == `MDR_MB_PRI && !remap_q)
                target_o = TGT_PRI; // R04
        end
    end

    // Peripheral slot and interrupt controller window
    assign per_slot_o = req_addr_i[`MDR_SLOT_LSB +: 8]; // R19
    assign aic_sel_o = per_hit && (per_slot_o == `MDR_AIC_SLOT) &&
        (req_addr_i[`MDR_SLOT_LSB-1:`MDR_AIC_LSB] == 2'b00); // R19

    // Abort generation; access still proceeds
    always_comb
    begin
        abort_o = 1'b0;
        if (req_i && space_o == SPACE_EXT && !int_hit)
            abort_o = !remap_q || !ext_addr_valid_i; // R14 R12
        else if (req_i && req_write_i && target_o == TGT_SEC && sec_protect_o)
            abort_o = 1'b1; // R15
    end
    assign access_ok_o = req_i; // R03 R15 R16

    // Single-cycle answer for internal memories
    single_cycle_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        req_i |-> access_ok_o) else $error("Request not answered"); // R03
    no_per_abort_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        (req_i && per_hit) |-> !abort_o) else $error("Peripheral abort"); // R16
    no_int_read_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        (req_i && int_hit && !req_write_i) |-> !abort_o)
        else $error("Internal read abort"); // R16
    word_align_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        per_hit |-> mem_addr_o[1:0] == 2'b00) else $error("Peripheral unaligned"); // R18
    remap_sticky_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        (remap_q && !wd_reset_i) |=> remap_q) else $error("Remap lost"); // R13
    remap_set_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        (remap_wr_i && remap_wdata_i[0] && !wd_reset_i) |=> remap_q)
        else $error("Remap not set"); // R11
    zero_pri_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        (remap_q && req_addr_i <= `MDR_VEC_TOP) |-> target_o == TGT_PRI)
        else $error("Vectors not from SRAM"); // R10
    prot_abort_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        (req_i && req_write_i && target_o == TGT_SEC && sec_protect_o) |-> abort_o)
        else $error("Protected write no abort"); // R15
    boot_keep_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        (rst_seen_q && wd_reset_i) |=> $stable(boot_q))
        else $error("Boot mode changed"); // R21
    pri_pre_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        (!remap_q && mb == `MDR_MB_PRI) |-> target_o == TGT_PRI)
        else $error("Primary SRAM not at base"); // R04
    ext_route_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        (!int_hit && !per_hit) |-> space_o == SPACE_EXT) else $error("Bad route"); // R17

    // Space routing
    per_space_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // R01
        per_hit |-> (space_o == SPACE_PER && target_o == TGT_PER))
        else $error("Peripheral route wrong");
    int_space_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // R01
        (int_hit && !per_hit) |-> space_o == SPACE_INT)
        else $error("Internal route wrong");
    ext_target_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // R17
        (!int_hit && !per_hit) |-> target_o == TGT_EXT)
        else $error("External target wrong");
    addr_pass_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // R02
        !per_hit |-> mem_addr_o == req_addr_i)
        else $error("Address altered");
    per_upper_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // R18
        per_hit |-> mem_addr_o[31:2] == req_addr_i[31:2])
        else $error("Peripheral word address altered");
    no_cs0_ext_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // R08
        !int_hit |-> !chip_select_zero_o)
        else $error("Boot select outside low space");

    // Internal memory map
    sec_base_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // R05
        (HAS_SEC && mb == `MDR_MB_SEC) |-> target_o == TGT_SEC)
        else $error("Secondary bank missing");
    pri_gone_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // R04
        (remap_q && mb == `MDR_MB_PRI) |-> target_o == TGT_NONE)
        else $error("Primary SRAM at old base");
    zero_sec_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // R22
        (!remap_q && mb == `MDR_MB_ZERO && boot_q == BOOT_INT) |-> target_o == TGT_SEC)
        else $error("Internal boot not at zero");
    zero_ext_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // R08
        (!remap_q && mb == `MDR_MB_ZERO && boot_q != BOOT_INT) |-> chip_select_zero_o)
        else $error("External boot not selected");
    cs0_only_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // R22
        chip_select_zero_o |-> (!remap_q && mb == `MDR_MB_ZERO))
        else $error("Boot select out of place");
    zero_any_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // R10
        (remap_q && mb == `MDR_MB_ZERO) |-> target_o == TGT_PRI)
        else $error("Zero not primary SRAM");

    // Protection and remap state
    prot_init_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // R06
        !rst_seen_q |-> prot_q)
        else $error("Not protected after reset");
    unprot_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // R06
        (mode_wr_i && mode_wdata_i == `MDR_MODE_UNPROT && !wd_reset_i) |=> !prot_q)
        else $error("Protection not lifted");
    reprot_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // R06
        (mode_wr_i && mode_wdata_i != `MDR_MODE_UNPROT) |=> prot_q)
        else $error("Protection not restored");
    wd_clear_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // R21
        wd_reset_i |=> (prot_q && !remap_q))
        else $error("Watchdog reset incomplete");
    remap_init_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // R13
        !rst_seen_q |-> !remap_q)
        else $error("Remap set after reset");
    remap_ignore_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // R13
        (!remap_q && !(remap_wr_i && remap_wdata_i[0])) |=> !remap_q)
        else $error("Remap set without write");

    // Abort
    ext_pre_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // R14
        (req_i && !int_hit && !per_hit && !remap_q) |-> abort_o)
        else $error("No abort before remap");
    ext_bad_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // R14
        (req_i && !int_hit && !per_hit && !ext_addr_valid_i) |-> abort_o)
        else $error("No abort on undefined address");
    ext_good_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // R14
        (req_i && !int_hit && !per_hit && remap_q && ext_addr_valid_i) |-> !abort_o)
        else $error("Abort on defined address");
    idle_abort_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // R14
        !req_i |-> !abort_o)
        else $error("Abort without request");
    open_write_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // R15
        (req_i && req_write_i && target_o == TGT_SEC && !sec_protect_o) |-> !abort_o)
        else $error("Abort on open write");
    int_write_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // R15
        (req_i && int_hit && target_o != TGT_SEC) |-> !abort_o)
        else $error("Abort on unprotected memory");
    ok_idle_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // R03
        !req_i |-> !access_ok_o)
        else $error("Answer without request");

    // Peripheral slots
    aic_per_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // R19
        aic_sel_o |-> per_hit)
        else $error("Interrupt window outside peripherals");
    aic_window_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // R19
        (per_hit && req_addr_i[`MDR_SLOT_LSB+7:`MDR_AIC_LSB] == {`MDR_AIC_SLOT, 2'b00}) |-> aic_sel_o)
        else $error("Interrupt window missed");
    aic_narrow_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // R19
        (req_addr_i[`MDR_SLOT_LSB-1:`MDR_AIC_LSB] != 2'b00) |-> !aic_sel_o)
        else $error("Interrupt window too wide");
    other_slot_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // R19
        (per_slot_o != `MDR_AIC_SLOT) |-> !aic_sel_o)
        else $error("Interrupt window in other slot");

    // Boot and reset release
    io_after_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // R09
        !rst_seen_q |=> io_line_24_en_o)
        else $error("Pad not handed over");
    boot_high_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // R07
        (!rst_seen_q && high_cnt_q == `MDR_BOOT_CYCLES) |=> boot_q != BOOT_EXT16)
        else $error("High boot level lost");
    boot_low_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // R08
        (!rst_seen_q && low_cnt_q == `MDR_BOOT_CYCLES) |=> boot_q == BOOT_EXT16)
        else $error("Low boot level lost");
    boot_hold_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // R21
        rst_seen_q |=> $stable(boot_q))
        else $error("Boot mode changed after reset");
    cnt_range_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // R07
        (high_cnt_q <= `MDR_BOOT_CYCLES && low_cnt_q <= `MDR_BOOT_CYCLES))
        else $error("Boot counter overrun");

    boot_int_c: cover property (@(posedge mclk_i) disable iff (sys_rst_i)
        rst_seen_q && boot_q == BOOT_INT);
    remap_c: cover property (@(posedge mclk_i) disable iff (sys_rst_i) $rose(remap_q));
    unprot_c: cover property (@(posedge mclk_i) disable iff (sys_rst_i) $fell(prot_q));
    abort_c: cover property (@(posedge mclk_i) disable iff (sys_rst_i) abort_o);
    aic_c: cover property (@(posedge mclk_i) disable iff (sys_rst_i) req_i && aic_sel_o);
endmodule

// File: testbench/core_bus_model.sv
/*
 * Behavioural model of the processor core issuing internal bus accesses.
 * Assumes the decoder answers combinationally within the same cycle.
 */
`timescale 1ns/1ps
module core_bus_model (
    // Clock
    input wire logic clk_i,
    // Request to the decoder
    output logic req_o,
    output logic write_o,
    output logic [1:0] size_o,
    output logic [31:0] addr_o
);
    initial
    begin
        req_o = 1'b0;
        write_o = 1'b0;
        size_o = 2'h2;
        addr_o = 32'h0;
    end
    // One access held for a whole cycle
    task automatic drive(input logic w, input logic [1:0] sz, input logic [31:0] a);
        @(posedge clk_i);
        #1;
        req_o = 1'b1;
        write_o = w;
        size_o = sz;
        addr_o = a;
    endtask
    // Released address toggles instead of holding the last value
    task automatic rest();
        @(posedge clk_i);
        #1;
        req_o = 1'b0;
        write_o = 1'b0;
        addr_o = ~addr_o;
    endtask
endmodule

// File: testbench/memory_decode_remap_tb_top.sv
/*
 * Directed bench of the memory decode and remap block.
 * Assumes the core model drives requests and the bench drives control writes.
 */
`timescale 1ns/1ps
module memory_decode_remap_tb_top;
    import memory_decode_remap_pkg::*;
    logic mclk_i = 1'b0, sys_rst_i = 1'b0, wd_reset_i = 1'b0, pin = 1'b0;
    logic req, wr, remap_wr = 1'b0, mode_wr = 1'b0, ext_ok = 1'b1;
    logic [1:0] sz;
    logic [31:0] addr, mem_addr, remap_wd = 32'h0, mode_wd = 32'h0;
    logic [7:0] slot;
    logic cs0, interrupt_controller_unit, abort, ok, remap_bit, prot, io_en, in_rst;
    space_e space;
    target_e tgt;
    boot_e boot;
    int fails = 0, check_count = 0;
    initial
    begin
        forever #2 mclk_i = ~mclk_i;
    end
    core_bus_model core_bus_model_i (.clk_i(mclk_i), .req_o(req), .write_o(wr), .size_o(sz),
        .addr_o(addr));
    memory_decode_remap memory_decode_remap_i (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
        .wd_reset_i(wd_reset_i), .boot_select_pin_i(pin), .req_i(req), .req_write_i(wr),
        .req_size_i(sz), .req_addr_i(addr), .remap_wr_i(remap_wr), .remap_wdata_i(remap_wd),
        .mode_wr_i(mode_wr), .mode_wdata_i(mode_wd), .ext_addr_valid_i(ext_ok),
        .space_o(space), .target_o(tgt), .mem_addr_o(mem_addr), .chip_select_zero_o(cs0),
        .per_slot_o(slot), .aic_sel_o(interrupt_controller_unit), .abort_o(abort), .access_ok_o(ok),
        .remap_bit_o(remap_bit), .sec_protect_o(prot), .boot_mode_o(boot),
        .io_line_24_en_o(io_en), .in_reset_o(in_rst));
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            fails++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Access, then decode outputs of that same cycle
    task automatic look(input logic w, input logic [31:0] a, input logic [1:0] s,
        input logic [2:0] t, input logic ab);
        core_bus_model_i.drive(w, 2'h2, a);
        #1;
        chk(space, s);
        chk(tgt, t);
        chk(abort, ab);
        chk(ok, 1'b1);
    endtask
    task automatic ctl(input logic rm, input logic [31:0] d);
        @(posedge mclk_i);
        #1;
        remap_wr = rm;
        mode_wr = !rm;
        remap_wd = d;
        mode_wd = d;
        @(posedge mclk_i);
        #1;
        remap_wr = 1'b0;
        mode_wr = 1'b0;
    endtask
    task automatic do_reset(input logic p);
        #1;
        pin = p;
        sys_rst_i = 1'b1;
        repeat (20) @(posedge mclk_i);
        #1;
        chk({in_rst, io_en, remap_bit, prot}, 4'b1001);
        sys_rst_i = 1'b0;
        repeat (2) @(posedge mclk_i);
        #1;
        chk({in_rst, io_en}, 2'b01);
        chk(boot, p ? BOOT_INT : BOOT_EXT16);
    endtask
    initial
    begin
        repeat (20000) @(posedge mclk_i);
        fails++;
        wrap_up();
    end
    initial
    begin
        do_reset(1'b0);
        core_bus_model_i.drive(1'b0, 2'h2, 32'h0);
        #1 chk({cs0, abort}, 2'b10);
        look(0, 32'h0030_0000, SPACE_INT, TGT_PRI, 0);
        look(1, 32'h0010_0000, SPACE_INT, TGT_SEC, 1);
        look(0, 32'h0010_0000, SPACE_INT, TGT_SEC, 0);
        look(0, 32'h0040_0000, SPACE_EXT, TGT_EXT, 1);
        core_bus_model_i.drive(1'b1, 2'h0, 32'hffff_c003);
        #1 chk(space, SPACE_PER);
        chk(tgt, TGT_PER);
        chk(abort, 1'b0);
        chk(mem_addr, 32'hffff_c000);
        chk({slot, interrupt_controller_unit}, {8'hff, 1'b1});
        look(0, 32'hffff_d000, SPACE_PER, TGT_PER, 0);
        chk({slot, interrupt_controller_unit}, {8'hff, 1'b0});
        core_bus_model_i.drive(1'b0, 2'h1, 32'hffc0_4002);
        #1 chk({slot, mem_addr}, {8'h01, 32'hffc0_4000});
        core_bus_model_i.rest();
        ctl(0, 32'h1);
        chk(prot, 1'b0);
        look(1, 32'h0010_0000, SPACE_INT, TGT_SEC, 0);
        ctl(1, 32'h0);
        chk(remap_bit, 1'b0);
        ctl(1, 32'h1);
        ctl(1, 32'h0);
        chk(remap_bit, 1'b1);
        look(0, 32'h0, SPACE_INT, TGT_PRI, 0);
        chk(cs0, 1'b0);
        ext_ok = 1'b0;
        look(1, 32'h0040_0000, SPACE_EXT, TGT_EXT, 1);
        ext_ok = 1'b1;
        look(0, 32'hffbf_fffc, SPACE_EXT, TGT_EXT, 0);
        pin = 1'b1;
        @(posedge mclk_i);
        #1 wd_reset_i = 1'b1;
        @(posedge mclk_i);
        #1 wd_reset_i = 1'b0;
        @(posedge mclk_i);
        #1 chk({remap_bit, prot, boot}, {2'b01, BOOT_EXT16});
        core_bus_model_i.rest();
        do_reset(1'b1);
        look(0, 32'h0, SPACE_INT, TGT_SEC, 0);
        chk(cs0, 1'b0);
        wrap_up();
    end
endmodule
